// ===== hdl/mmvd_top.sv
// Memory map and vector decode: RAM window, stack engine, vector table,
// high-memory control bytes and watchdog service, behind an APB slave.
// Assumes an APB master on pclk and core strobes on the same clock.
//
// Contract
// - 128-byte RAM at 0x0080 to 0x00FF
// - Sixteen-bit stack pointer spans whole space
// - Interrupt entry pushes exactly five bytes
// - Index-high register never pushed on entry
// - Subroutine call pushes two return bytes
// - Push decrements, pull increments stack pointer
// - Conversion vector at 0xFFDE, lowest priority
// - Timer vectors at 0xFFF2, 0xFFF4, 0xFFF6
// - Fixed priority from reset down to conversion
// - Any write to 0xFFFF with pstrb[0] set clears watchdog
// - Trim byte at 0xFFC0 survives reset
// - Low-voltage flag bit 7, rest zero
// - Break enable and active bits, reset zero
// - Flash test bytes change no visible state
//
// Design decision made here: the APB register port.
`include "mmvd_cfg.svh"
`default_nettype none
module mmvd_top #(
    parameter int unsigned WDOG_CYCLES = `MMVD_WDOG_CYCLES
) (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // APB slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [17:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic                      irq,
    // Stack port from the core
    input  wire logic                 int_enter,
    input  wire logic                 call_enter,
    input  wire logic                 push_req,
    input  wire logic                 pull_req,
    input  wire logic                 sp_load,
    input  wire mmvd_pkg::mmvd_addr_t sp_load_val,
    input  wire mmvd_pkg::mmvd_addr_t ctx_pc,
    input  wire mmvd_pkg::mmvd_byte_t ctx_x,
    input  wire mmvd_pkg::mmvd_byte_t ctx_a,
    input  wire mmvd_pkg::mmvd_byte_t ctx_ccr,
    input  wire mmvd_pkg::mmvd_byte_t push_data,
    output logic                      stk_busy,
    output mmvd_pkg::mmvd_addr_t      sp_value,
    output mmvd_pkg::mmvd_byte_t      pull_data,
    output logic                      pull_valid,
    // Vector fetch
    input  wire logic                 vec_fetch,
    input  wire logic                 reset_src,
    input  wire logic                 software_interrupt,
    input  wire logic                 external_pin_source,
    input  wire logic                 timer_ch0_source,
    input  wire logic                 timer_ch1_source,
    input  wire logic                 timer_overflow_source,
    input  wire logic                 keypad_source,
    input  wire logic                 analog_done_source,
    output mmvd_pkg::mmvd_addr_t      vec_addr,
    output mmvd_pkg::mmvd_addr_t      vec_data,
    output logic                      vec_valid,
    // Pins and control outputs
    input  wire logic                 low_voltage_pin,
    output logic                      break_enable_bit,
    output logic                      break_active_bit,
    output logic                      watchdog_timer_reset
);
    import mmvd_pkg::*;

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    mmvd_byte_t  ram_mem [128];
    mmvd_byte_t  vec_mem [6'h10:6'h3F];
    mmvd_state_t state_r;
    mmvd_addr_t  sp_r;
    logic [39:0] ctx_r;
    logic [2:0]  cnt_r;
    logic [1:0]  brk_r;
    mmvd_byte_t  prot_r;
    mmvd_byte_t  trim_r;
    logic [2:0]  stat_r;
    logic [2:0]  stat_nxt;
    logic [2:0]  en_r;
    logic [17:0] wdog_cnt_r;
    logic        lv_s1_r;
    logic        lv_s2_r;
    logic        lv_d_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        irq_r;
    mmvd_byte_t  pull_data_r;
    logic        pull_valid_r;
    mmvd_addr_t  vec_addr_r;
    mmvd_addr_t  vec_data_r;
    logic        vec_valid_r;
    logic        wdog_rst_r;
    mmvd_byte_t  rd_byte;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire mmvd_addr_t adr       = paddr[17:2];
    wire logic       idle      = (state_r == ST_IDLE);
    wire logic       stk_start = idle && (int_enter || call_enter
                                          || push_req);
    wire logic       pull_go   = idle && pull_req && !stk_start;
    wire logic       apb_go    = psel && penable && !pready_r && idle
                                 && !stk_start && !pull_go;
    // Writes land on the edge that completes the access, as the master
    // sees it, so nothing changes before pready is sampled high.
    wire logic       wr_go     = psel && penable && pready_r && pwrite
                                 && pstrb[0];
    wire logic       rd_go     = apb_go && !pwrite;
    wire mmvd_byte_t wbyte     = pwdata[7:0];
    wire logic       in_ram    = (adr >= `MMVD_RAM_LO)
                                 && (adr <= `MMVD_RAM_HI);
    wire logic       in_vec    = (adr >= `MMVD_ADR_VBASE);
    wire logic [5:0] vi        = adr[5:0];
    // Only documented vector bytes are stored; the reset low byte is fixed.
    wire logic       vec_used  = (vi >= 6'h1E && vi <= 6'h21)
                                 || (vi >= 6'h32 && vi <= 6'h37)
                                 || (vi >= 6'h3A && vi <= 6'h3E);
    wire logic       wdog_clr  = wr_go && (adr == `MMVD_ADR_WDOG);
    wire logic       sp_in_ram = (sp_r >= `MMVD_RAM_LO)
                                 && (sp_r <= `MMVD_RAM_HI);
    wire mmvd_addr_t sp_inc    = sp_r + 16'h0001;
    wire logic       sp_inc_ok = (sp_inc >= `MMVD_RAM_LO)
                                 && (sp_inc <= `MMVD_RAM_HI);
    // Stacking outside RAM is the software's fault; it is flagged, not fixed.
    wire logic       stk_err   = ((state_r == ST_PUSH) && !sp_in_ram)
                                 || (pull_go && !sp_inc_ok);
    wire logic [17:0] wdog_lim = 18'(WDOG_CYCLES - 1);
    wire logic       wdog_exp  = !wdog_clr && (wdog_cnt_r == wdog_lim);
    wire logic       lv_rise   = lv_s2_r && !lv_d_r;
    wire logic [2:0] ev        = {lv_rise, wdog_exp, stk_err};
    wire logic [2:0] clr_mask  = (wr_go && adr == `MMVD_ADR_CLR)
                                 ? pwdata[2:0] : 3'h0;

    // Priority from reset down to the conversion source.
    wire mmvd_addr_t vsel = reset_src             ? `MMVD_VEC_RST
                          : software_interrupt    ? `MMVD_VEC_SWI
                          : external_pin_source   ? `MMVD_VEC_EXT
                          : timer_ch0_source      ? `MMVD_VEC_TCH0
                          : timer_ch1_source      ? `MMVD_VEC_TCH1
                          : timer_overflow_source ? `MMVD_VEC_TOVF
                          : keypad_source         ? `MMVD_VEC_KBD
                          : `MMVD_VEC_ADC;
    wire logic [5:0] vsel_lo = vsel[5:0] + 6'h01;
    wire mmvd_byte_t vlo     = (vsel == `MMVD_VEC_RST)
                               ? `MMVD_RST_VEC_LO : vec_mem[vsel_lo];

    always_comb begin
        if (in_ram) begin
            rd_byte = ram_mem[adr[6:0]];
        end else if (adr == `MMVD_ADR_BRK) begin
            rd_byte = {brk_r, 6'h00};
        end else if (adr == `MMVD_ADR_LVS) begin
            rd_byte = {lv_s2_r, 7'h00};
        end else if (adr == `MMVD_ADR_STAT) begin
            rd_byte = {5'h00, stat_r};
        end else if (adr == `MMVD_ADR_EN) begin
            rd_byte = {5'h00, en_r};
        end else if (adr == `MMVD_ADR_SP_HI) begin
            rd_byte = sp_r[15:8];
        end else if (adr == `MMVD_ADR_SP_LO) begin
            rd_byte = sp_r[7:0];
        end else if (adr == `MMVD_ADR_PROT) begin
            rd_byte = prot_r;
        end else if (adr == `MMVD_ADR_TRIM) begin
            rd_byte = trim_r;
        end else if (adr == `MMVD_ADR_WDOG) begin
            rd_byte = `MMVD_RST_VEC_LO;
        end else if (in_vec && vec_used) begin
            rd_byte = vec_mem[vi];
        end else begin
            rd_byte = 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else begin
            pready_r <= apb_go;
            prdata_r <= rd_go ? {24'h00_0000, rd_byte} : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Stack engine
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r      <= ST_IDLE;
            sp_r         <= `MMVD_SP_RST;
            ctx_r        <= 40'h00_0000_0000;
            cnt_r        <= 3'h0;
            pull_data_r  <= 8'h00;
            pull_valid_r <= 1'b0;
        end else begin
            pull_valid_r <= pull_go;
            if (state_r == ST_PUSH) begin
                sp_r    <= sp_r - 16'h0001;
                ctx_r   <= {8'h00, ctx_r[39:8]};
                cnt_r   <= cnt_r - 3'h1;
                state_r <= (cnt_r == 3'h1) ? ST_IDLE : ST_PUSH;
            end else if (int_enter) begin
                // Low PC first; no index-high byte joins the frame.
                ctx_r   <= {ctx_ccr, ctx_a, ctx_x, ctx_pc[15:8],
                            ctx_pc[7:0]};
                cnt_r   <= `MMVD_CTX_BYTES;
                state_r <= ST_PUSH;
            end else if (call_enter) begin
                ctx_r   <= {24'h00_0000, ctx_pc[15:8], ctx_pc[7:0]};
                cnt_r   <= `MMVD_CALL_BYTES;
                state_r <= ST_PUSH;
            end else if (push_req) begin
                ctx_r   <= {32'h0000_0000, push_data};
                cnt_r   <= 3'h1;
                state_r <= ST_PUSH;
            end else if (pull_req) begin
                sp_r        <= sp_inc;
                pull_data_r <= sp_inc_ok ? ram_mem[sp_inc[6:0]] : 8'h00;
            end else if (sp_load) begin
                sp_r <= sp_load_val;
            end
        end
    end

    // RAM and vector table hold no reset; the engine owns RAM while busy.
    always_ff @(posedge pclk) begin
        if ((state_r == ST_PUSH) && sp_in_ram) begin
            ram_mem[sp_r[6:0]] <= ctx_r[7:0];
        end else if (wr_go && in_ram) begin
            ram_mem[adr[6:0]] <= wbyte;
        end
        if (wr_go && in_vec && vec_used) begin
            vec_mem[vi] <= wbyte;
        end
        if (wr_go && adr == `MMVD_ADR_PROT) begin
            prot_r <= wbyte;
        end
        if (wr_go && adr == `MMVD_ADR_TRIM) begin
            trim_r <= wbyte;
        end
    end

    // ------------------------------------------------------------------
    // Control registers, watchdog, vector fetch, interrupt
    // ------------------------------------------------------------------
    // Set wins over a clear written in the same cycle.
    assign stat_nxt = (stat_r & ~clr_mask) | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brk_r       <= `MMVD_BRK_RST;
            en_r        <= `MMVD_EN_RST;
            stat_r      <= 3'h0;
            irq_r       <= 1'b0;
            wdog_cnt_r  <= 18'h0_0000;
            wdog_rst_r  <= 1'b0;
            lv_s1_r     <= 1'b0;
            lv_s2_r     <= 1'b0;
            lv_d_r      <= 1'b0;
            vec_addr_r  <= 16'h0000;
            vec_data_r  <= 16'h0000;
            vec_valid_r <= 1'b0;
        end else begin
            if (wr_go && adr == `MMVD_ADR_BRK) begin
                brk_r <= pwdata[`MMVD_BRK_EN_BIT:`MMVD_BRK_ACT_BIT];
            end
            if (wr_go && adr == `MMVD_ADR_EN) begin
                en_r <= pwdata[2:0];
            end
            stat_r  <= stat_nxt;
            irq_r   <= |(stat_nxt & en_r);
            lv_s1_r <= low_voltage_pin;
            lv_s2_r <= lv_s1_r;
            lv_d_r  <= lv_s2_r;
            if (wdog_clr || wdog_exp) begin
                wdog_cnt_r <= 18'h0_0000;
            end else begin
                wdog_cnt_r <= wdog_cnt_r + 18'h0_0001;
            end
            wdog_rst_r  <= wdog_exp;
            vec_valid_r <= vec_fetch;
            if (vec_fetch) begin
                vec_addr_r <= vsel;
                vec_data_r <= {vec_mem[vsel[5:0]], vlo};
            end
        end
    end

    assign prdata               = prdata_r;
    assign pready               = pready_r;
    assign pslverr              = 1'b0;
    assign irq                  = irq_r;
    assign stk_busy             = state_r;
    assign sp_value             = sp_r;
    assign pull_data            = pull_data_r;
    assign pull_valid           = pull_valid_r;
    assign vec_addr             = vec_addr_r;
    assign vec_data             = vec_data_r;
    assign vec_valid            = vec_valid_r;
    assign break_enable_bit     = brk_r[1];
    assign break_active_bit     = brk_r[0];
    assign watchdog_timer_reset = wdog_rst_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_int_acc;
        idle && int_enter;
    endsequence
    sequence s_call_acc;
        idle && !int_enter && call_enter;
    endsequence

    property p_int_five;
        s_int_acc |=> (state_r == ST_PUSH) [*5] ##1
            (idle && sp_r == $past(sp_r, 6) - 16'h0005);
    endproperty
    a_int_five: assert property (p_int_five)
        else $error("interrupt entry did not push five bytes");

    property p_call_two;
        s_call_acc |=> (state_r == ST_PUSH) [*2] ##1
            (idle && sp_r == $past(sp_r, 3) - 16'h0002);
    endproperty
    a_call_two: assert property (p_call_two)
        else $error("call did not push two bytes");

    property p_pull_inc;
        pull_go |=> sp_r == $past(sp_r) + 16'h0001 && pull_valid_r;
    endproperty
    a_pull_inc: assert property (p_pull_inc)
        else $error("pull did not increment stack pointer");

    property p_wdog_clr;
        wdog_clr |=> wdog_cnt_r == 18'h0_0000 && !wdog_rst_r;
    endproperty
    a_wdog_clr: assert property (p_wdog_clr)
        else $error("watchdog write did not clear counter");

    property p_vec_prio;
        vec_fetch && external_pin_source && !reset_src
            && !software_interrupt |=> vec_valid_r
            && vec_addr_r == `MMVD_VEC_EXT;
    endproperty
    a_vec_prio: assert property (p_vec_prio)
        else $error("external source lost priority");

    property p_rd_wdog;
        rd_go && adr == `MMVD_ADR_WDOG |=> pready_r
            && prdata_r == {24'h00_0000, `MMVD_RST_VEC_LO};
    endproperty
    a_rd_wdog: assert property (p_rd_wdog)
        else $error("read of service location not reset vector");

    property p_lvs_zero;
        rd_go && adr == `MMVD_ADR_LVS |=> prdata_r[6:0] == 7'h00
            && prdata_r[7] == $past(lv_s2_r);
    endproperty
    a_lvs_zero: assert property (p_lvs_zero)
        else $error("low-voltage status read wrong");

    property p_trim_keep;
        wr_go && adr == `MMVD_ADR_TRIM |=> trim_r == $past(wbyte);
    endproperty
    a_trim_keep: assert property (p_trim_keep)
        else $error("trim byte not stored");

    property p_brk_wr;
        wr_go && adr == `MMVD_ADR_BRK |=> brk_r == $past(pwdata[7:6]);
    endproperty
    a_brk_wr: assert property (p_brk_wr)
        else $error("break control write not stored");
endmodule
`default_nettype wire

// ===== hdl/mmvd_cfg.svh
// Address map, field positions, reset values and timing counts of the
// memory map and vector decode block.
// Assumes a 16-bit core address carried on APB as a word index (paddr/4).
`ifndef MMVD_CFG_SVH
`define MMVD_CFG_SVH
// ----------------------------------------------------------------------
// Address map (core byte addresses, each one APB word index)
// ----------------------------------------------------------------------
`define MMVD_RAM_LO      16'h0080
`define MMVD_RAM_HI      16'h00FF
`define MMVD_ADR_BRK     16'hFE0B
`define MMVD_ADR_LVS     16'hFE0C
`define MMVD_ADR_FT_LO   16'hFE0D
`define MMVD_ADR_FT_HI   16'hFE0F
`define MMVD_ADR_STAT    16'hFE20
`define MMVD_ADR_CLR     16'hFE21
`define MMVD_ADR_EN      16'hFE22
`define MMVD_ADR_SP_HI   16'hFE23
`define MMVD_ADR_SP_LO   16'hFE24
`define MMVD_ADR_PROT    16'hFFBE
`define MMVD_ADR_TRIM    16'hFFC0
`define MMVD_ADR_VBASE   16'hFFD0
`define MMVD_ADR_WDOG    16'hFFFF
`define MMVD_VEC_ADC     16'hFFDE
`define MMVD_VEC_KBD     16'hFFE0
`define MMVD_VEC_TOVF    16'hFFF2
`define MMVD_VEC_TCH1    16'hFFF4
`define MMVD_VEC_TCH0    16'hFFF6
`define MMVD_VEC_EXT     16'hFFFA
`define MMVD_VEC_SWI     16'hFFFC
`define MMVD_VEC_RST     16'hFFFE
// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define MMVD_BRK_EN_BIT  7
`define MMVD_BRK_ACT_BIT 6
`define MMVD_LV_FLAG_BIT 7
`define MMVD_ST_STK_BIT  0
`define MMVD_ST_WDG_BIT  1
`define MMVD_ST_LV_BIT   2
`define MMVD_BRK_RST     2'h0
`define MMVD_EN_RST      3'h0
`define MMVD_SP_RST      16'h00FF
`define MMVD_RST_VEC_LO  8'h00
// ----------------------------------------------------------------------
// Stack byte counts and timing
// ----------------------------------------------------------------------
`define MMVD_CTX_BYTES   3'h5
`define MMVD_CALL_BYTES  3'h2
`define MMVD_CLK_MHZ     25
`define MMVD_WDOG_US     10000
`define MMVD_WDOG_CYCLES (`MMVD_WDOG_US * `MMVD_CLK_MHZ)
`endif

// ===== hdl/mmvd_pkg.sv
// Types shared by the memory map and vector decode block.
// Assumes the constants of mmvd_cfg.svh.
`default_nettype none
package mmvd_pkg;
    typedef logic [7:0] mmvd_byte_t;
    typedef logic [15:0] mmvd_addr_t;
    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_PUSH = 1'b1
    } mmvd_state_t;
endpackage
`default_nettype wire

// ===== bench/mmvd_core_model.sv
// Core stand-in: drives stack strobes, context and vector fetches.
// Assumes one clock shared with the block under test.
`default_nettype none
module mmvd_core_model #(
    parameter logic [15:0] PC  = 16'h1234,
    parameter logic [23:0] XAC = 24'h56789A
) (
    // Clock and answers from the block
    input  wire logic   pclk,
    input  wire logic   stk_busy,
    input  wire logic   pull_valid,
    input  wire logic   vec_valid,
    // Strobes, data and sources to the block
    output logic [4:0]  stb,
    output logic [15:0] sp_load_val,
    output logic [15:0] ctx_pc,
    output logic [23:0] ctx_xac,
    output logic [7:0]  push_data,
    output logic        vec_fetch,
    output logic [7:0]  src
);
    timeunit 1ns;
    timeprecision 1ps;
    assign ctx_pc = PC;
    assign ctx_xac = XAC;
    initial begin
        stb = '0;
        sp_load_val = '0;
        push_data = '0;
        vec_fetch = 1'b0;
        src = '0;
    end
    // Strobe k for one cycle, then count busy cycles; the caller picks the
    // stack base, and only the stack-error scenario leaves RAM on purpose.
    task automatic stk(input int k, input logic [15:0] v,
                       input logic [7:0] d, output int n, output logic pv);
        @(posedge pclk);
        stb <= 5'(1 << k);
        sp_load_val <= v;
        push_data <= d;
        @(posedge pclk);
        stb <= '0;
        n = 0;
        @(posedge pclk);
        pv = pull_valid;
        while (stk_busy === 1'b1) begin
            n++;
            @(posedge pclk);
        end
    endtask
    task automatic vf(input logic [7:0] s, output logic vv);
        @(posedge pclk);
        vec_fetch <= 1'b1;
        src <= s;
        @(posedge pclk);
        vec_fetch <= 1'b0;
        src <= '0;
        @(posedge pclk);
        vv = vec_valid;
    endtask
endmodule
`default_nettype wire

// ===== bench/memory_map_vector_decode_test.sv
// Bench: APB and core stimulus with expected values, single clock.
// Assumes mmvd_top with a short watchdog count.
`default_nettype none
module memory_map_vector_decode_test;
    timeunit 1ns;
    timeprecision 1ps;
    import mmvd_pkg::*;
    localparam logic [15:0] PC = 16'h1234;
    localparam logic [23:0] XAC = 24'h56789A;
    localparam logic [15:0] VA [8] = '{16'hFFFE, 16'hFFFC, 16'hFFFA,
        16'hFFF6, 16'hFFF4, 16'hFFF2, 16'hFFE0, 16'hFFDE};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lv = 0;
    logic [17:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0] pstrb = '0;
    logic [31:0] prdata;
    logic pready, irq, busy, pv, vv, be, ba, vfe, ok, wdr, perr;
    logic [4:0] stb;
    logic [7:0] src, pd;
    logic [15:0] spl, pc;
    logic [23:0] xac;
    logic [39:0] ctx;
    mmvd_addr_t sp_value, vec_addr, vec_data;
    mmvd_byte_t pull_data, rd;
    int error_cnt = 0, num_checks = 0, cyc = 0, n, wd_cnt = 0;
    always #20 pclk = ~pclk;
    mmvd_top #(.WDOG_CYCLES(20)) u_mmvd_top (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(perr), .irq(irq), .int_enter(stb[0]), .call_enter(stb[1]),
        .push_req(stb[2]), .pull_req(stb[3]), .sp_load(stb[4]),
        .sp_load_val(spl), .ctx_pc(pc), .ctx_x(xac[23:16]),
        .ctx_a(xac[15:8]), .ctx_ccr(xac[7:0]), .push_data(pd),
        .stk_busy(busy), .sp_value(sp_value), .pull_data(pull_data),
        .pull_valid(pv), .vec_fetch(vfe), .reset_src(src[0]),
        .software_interrupt(src[1]), .external_pin_source(src[2]),
        .timer_ch0_source(src[3]), .timer_ch1_source(src[4]),
        .timer_overflow_source(src[5]), .keypad_source(src[6]),
        .analog_done_source(src[7]), .vec_addr(vec_addr),
        .vec_data(vec_data), .vec_valid(vv), .low_voltage_pin(lv),
        .break_enable_bit(be), .break_active_bit(ba),
        .watchdog_timer_reset(wdr));
    mmvd_core_model #(.PC(PC), .XAC(XAC)) u_mmvd_core_model (.pclk(pclk),
        .stk_busy(busy), .pull_valid(pv), .vec_valid(vv), .stb(stb),
        .sp_load_val(spl), .ctx_pc(pc), .ctx_xac(xac), .push_data(pd),
        .vec_fetch(vfe), .src(src));
    task automatic results;
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk8(input mmvd_byte_t g, input mmvd_byte_t e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk16(input mmvd_addr_t g, input mmvd_addr_t e);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input mmvd_addr_t a,
                       input mmvd_byte_t d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {a, 2'b00};
        pwdata <= {24'h00_0000, d};
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata[7:0];
        chk8({7'h00, perr}, 8'h00);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input mmvd_addr_t a, input mmvd_byte_t d);
        apb(1'b1, a, d, 4'h1);
    endtask
    task automatic rdc(input mmvd_addr_t a, input mmvd_byte_t e);
        apb(1'b0, a, 8'h00, 4'h0);
        chk8(rd, e);
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (wdr === 1'b1) wd_cnt++;
        if (cyc == 20000) begin
            error_cnt++;
            results;
        end
    end
    initial begin
        ctx = {PC[7:0], PC[15:8], XAC};
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdc(16'hFE0B, 8'h00);
        rdc(16'hFE0C, 8'h00);
        wr(16'hFE0B, 8'hFF);
        rdc(16'hFE0B, 8'hC0);
        chk8({6'h00, be, ba}, 8'h03);
        wr(16'hFE0C, 8'hFF);
        wr(16'hFE0D, 8'h55);
        wr(16'hFE0F, 8'h55);
        wr(16'hFFBF, 8'h77);
        rdc(16'hFE0C, 8'h00);
        rdc(16'hFE0B, 8'hC0);
        rdc(16'hFE0D, 8'h00);
        rdc(16'hFFBF, 8'h00);
        rdc(16'hFFE2, 8'h00);
        wr(16'hFFC0, 8'h5A);
        wr(16'hFFBE, 8'h3C);
        wr(16'h0080, 8'h11);
        wr(16'h00FF, 8'hEE);
        apb(1'b1, 16'h00FF, 8'h99, 4'h0);
        lv <= 1'b1;
        repeat (4) @(posedge pclk);
        rdc(16'hFE0C, 8'h80);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc(16'hFFC0, 8'h5A);
        rdc(16'hFFBE, 8'h3C);
        rdc(16'h0080, 8'h11);
        rdc(16'h00FF, 8'hEE);
        rdc(16'hFE0B, 8'h00);
        rdc(16'hFFFF, 8'h00);
        wr(16'hFFFF, 8'h00);
        wr(16'hFE21, 8'h07);
        n = wd_cnt;
        for (int i = 0; i < 12; i++) wr(16'hFFFF, 8'(i * 21));
        apb(1'b0, 16'hFE20, 8'h00, 4'h0);
        chk8(rd & 8'h02, 8'h00);
        chk8(8'(wd_cnt - n), 8'h00);
        repeat (30) @(posedge pclk);
        apb(1'b0, 16'hFE20, 8'h00, 4'h0);
        chk8(rd & 8'h02, 8'h02);
        chk8({7'h00, (wd_cnt > n)}, 8'h01);
        u_mmvd_core_model.stk(4, 16'h0200, 8'h00, n, ok);
        chk16(sp_value, 16'h0200);
        rdc(16'hFE23, 8'h02);
        wr(16'hFE22, 8'h01);
        u_mmvd_core_model.stk(2, 16'h0000, 8'hA5, n, ok);
        repeat (2) @(posedge pclk);
        chk8({7'h00, irq}, 8'h01);
        wr(16'hFE22, 8'h00);
        repeat (2) @(posedge pclk);
        chk8({7'h00, irq}, 8'h00);
        wr(16'hFE22, 8'h01);
        wr(16'hFE21, 8'h01);
        repeat (2) @(posedge pclk);
        chk8({7'h00, irq}, 8'h00);
        u_mmvd_core_model.stk(4, 16'h00F0, 8'h00, n, ok);
        u_mmvd_core_model.stk(2, 16'h0000, 8'hA5, n, ok);
        chk8(8'(n), 8'h01);
        chk16(sp_value, 16'h00EF);
        u_mmvd_core_model.stk(3, 16'h0000, 8'h00, n, ok);
        chk8({7'h00, ok}, 8'h01);
        chk8(pull_data, 8'hA5);
        chk16(sp_value, 16'h00F0);
        wr(16'h00EB, 8'hC3);
        u_mmvd_core_model.stk(0, 16'h0000, 8'h00, n, ok);
        chk8(8'(n), 8'h05);
        chk16(sp_value, 16'h00EB);
        for (int i = 0; i < 5; i++) rdc(16'(240 - i), ctx[39-8*i-:8]);
        rdc(16'h00EB, 8'hC3);
        u_mmvd_core_model.stk(1, 16'h0000, 8'h00, n, ok);
        chk8(8'(n), 8'h02);
        chk16(sp_value, 16'h00E9);
        rdc(16'h00EA, PC[15:8]);
        for (int i = 0; i < 8; i++) begin
            wr(VA[i], 8'(16 + i));
            if (i > 0) wr(VA[i] + 16'h0001, 8'(32 + i));
        end
        for (int i = 0; i < 8; i++) begin
            u_mmvd_core_model.vf(8'(8'hFF << i), ok);
            chk8({7'h00, ok}, 8'h01);
            chk16(vec_addr, VA[i]);
            chk16(vec_data, {8'(16 + i), i > 0 ? 8'(32 + i) : 8'h00});
        end
        results;
    end
endmodule
`default_nettype wire
